// File: gyro_cond_pkg.sv
// constants for the gyro output conditioning block: register indices,
// field positions, reset values, rate selection and tick periods.
// assumes a single 50 MHz register clock; indices are word indices.
package gyro_cond_pkg;

  localparam int AXES = 3;

  // register indices; byte address is four times the index
  localparam logic [7:0] TC_HI_IDX [AXES]   = '{8'h04, 8'h07, 8'h0A};
  localparam logic [7:0] TC_LO_IDX [AXES]   = '{8'h05, 8'h08, 8'h0B};
  localparam logic [7:0] UOFF_HI_IDX [AXES] = '{8'h13, 8'h15, 8'h17};
  localparam logic [7:0] UOFF_LO_IDX [AXES] = '{8'h14, 8'h16, 8'h18};
  localparam logic [7:0] GOUT_HI_IDX [AXES] = '{8'h43, 8'h45, 8'h47};
  localparam logic [7:0] GOUT_LO_IDX [AXES] = '{8'h44, 8'h46, 8'h48};
  localparam logic [7:0] DIV_IDX            = 8'h19;
  localparam logic [7:0] CFG_IDX            = 8'h1A;
  localparam logic [7:0] GCFG_IDX           = 8'h1B;
  localparam logic [7:0] PWR_IDX            = 8'h6B;

  // field positions
  localparam int TC_HI_BITS     = 2;
  localparam int LPC_LSB        = 0;
  localparam int FPS_LSB        = 0;
  localparam int PWR_RESET_BIT  = 7;
  localparam int PWR_SLEEP_BIT  = 6;
  localparam logic [7:0] CFG_MASK  = 8'h7F;
  localparam logic [7:0] GCFG_MASK = 8'hFB;
  localparam logic [7:0] PWR_MASK  = 8'h7F;

  // reset values
  localparam logic [7:0]  REG_RESET  = 8'h00;
  localparam logic [15:0] UOFF_RESET = 16'h0000;

  // temperature product scaling into the output lsb
  localparam int COMP_SHIFT = 8;

  // base rates
  localparam int CLK_HZ   = 50_000_000;
  localparam int RATE_1K  = 1_000;
  localparam int RATE_8K  = 8_000;
  localparam int RATE_32K = 32_000;
  localparam int CYC_1K   = CLK_HZ / RATE_1K;
  localparam int CYC_8K   = CLK_HZ / RATE_8K;
  localparam int CYC_32K  = CLK_HZ / RATE_32K;

  typedef enum logic [1:0] {
    RATE_SEL_1K  = 2'b00,
    RATE_SEL_8K  = 2'b01,
    RATE_SEL_32K = 2'b10
  } rate_sel_t;

endpackage

// File: base_tick_gen.sv
// base output-rate tick generator: one-cycle pulse at 1, 8 or 32 kHz.
// assumes rate_sel changes only from register writes on pclk.
`timescale 1ns/1ns
module base_tick_gen #(
  parameter int CYC_1K_P  = 50000,
  parameter int CYC_8K_P  = 6250,
  parameter int CYC_32K_P = 1562
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   restart,
  input  wire gyro_cond_pkg::rate_sel_t rate_sel,
  output logic                        tick
);
  import gyro_cond_pkg::*;

  logic [15:0] cnt_reg;
  logic [15:0] last_reg;
  rate_sel_t   sel_reg;

  function automatic logic [15:0] period_last(input rate_sel_t s);
    unique case (s)
      RATE_SEL_1K:  period_last = 16'(CYC_1K_P - 1);
      RATE_SEL_8K:  period_last = 16'(CYC_8K_P - 1);
      RATE_SEL_32K: period_last = 16'(CYC_32K_P - 1);
      default:      period_last = 16'(CYC_1K_P - 1);
    endcase
  endfunction

  assign last_reg = period_last(sel_reg);
  assign tick     = (cnt_reg == last_reg);

  // a rate change restarts the period so no short first tick appears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 16'h0000;
      sel_reg <= RATE_SEL_1K;
    end else if (restart || rate_sel != sel_reg) begin
      cnt_reg <= 16'h0000;
      sel_reg <= rate_sel;
    end else if (tick) begin
      cnt_reg <= 16'h0000;
    end else begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end
endmodule

// File: axis_condition.sv
// per-axis conditioning: raw sample minus user offset minus temperature
// term; purely combinational, results wrap at 16 bits.
`timescale 1ns/1ns
module axis_condition (
  input  wire logic signed [15:0] raw,
  input  wire logic signed [15:0] user_offset,
  input  wire logic signed [9:0]  temp_compensation,
  input  wire logic signed [15:0] temp_delta,
  output logic signed [15:0]      result
);
  import gyro_cond_pkg::*;

  logic signed [25:0] prod;
  logic signed [15:0] comp;

  // a zero coefficient gives a zero product, so no temperature effect
  assign prod   = temp_compensation * temp_delta;
  assign comp   = prod[COMP_SHIFT+15:COMP_SHIFT];
  assign result = raw - user_offset - comp;
endmodule

// File: gyro_offset_and_sample_rate.sv
// gyro offset conditioning and sample-rate pacing behind an APB slave.
// assumes raw samples, temperature and trim inputs are on pclk.
`timescale 1ns/1ns
module gyro_offset_and_sample_rate #(
  parameter int CYC_1K_P = gyro_cond_pkg::CYC_1K,
  parameter int CYC_8K_P = gyro_cond_pkg::CYC_8K
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] raw_x,
  input  wire logic [15:0] raw_y,
  input  wire logic [15:0] raw_z,
  input  wire logic [15:0] temp_delta,
  input  wire logic [9:0]  trim_x,
  input  wire logic [9:0]  trim_y,
  input  wire logic [9:0]  trim_z,
  output logic [15:0]      gyro_x_out,
  output logic [15:0]      gyro_y_out,
  output logic [15:0]      gyro_z_out,
  output logic             fifo_push,
  output logic             sleep_out
);
  import gyro_cond_pkg::*;

  logic [9:0]  tc_reg   [AXES];
  logic [15:0] uoff_reg [AXES];
  logic [15:0] gout_reg [AXES];
  logic [15:0] cond     [AXES];
  logic [15:0] raw      [AXES];
  logic [9:0]  trim     [AXES];
  logic [7:0]  div_reg;
  logic [7:0]  cfg_reg;
  logic [7:0]  gcfg_reg;
  logic        sleep_reg;
  logic        load_pending_reg;
  logic [7:0]  div_cnt_reg;
  logic        fifo_push_reg;
  logic [7:0]  idx;
  logic        addr_ok;
  logic        hit;
  logic [7:0]  rd_byte;
  logic        wr_en;
  logic        soft_rst;
  logic [1:0]  filter_path_select;
  logic [2:0]  lowpass_config;
  logic        div_effective;
  rate_sel_t   base_sel;
  logic        base_tick;
  logic        sample_strobe;

  assign raw  = '{raw_x, raw_y, raw_z};
  assign trim = '{trim_x, trim_y, trim_z};

  //////////////////////////////////////////////////////////////////////////
  // apb decode

  function automatic logic is_ro(input logic [7:0] i);
    is_ro = 1'b0;
    for (int a = 0; a < AXES; a++) begin
      if (i == GOUT_HI_IDX[a] || i == GOUT_LO_IDX[a]) begin
        is_ro = 1'b1;
      end
    end
  endfunction

  assign idx     = paddr[9:2];
  assign addr_ok = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;
  // writes to output registers are ignored, not refused
  assign wr_en   = psel && penable && pwrite && hit && pstrb[0] && !is_ro(idx);
  assign soft_rst = wr_en && idx == PWR_IDX && pwdata[PWR_RESET_BIT];

  always_comb begin
    hit     = 1'b0;
    rd_byte = REG_RESET;
    if (addr_ok) begin
      for (int a = 0; a < AXES; a++) begin
        if (idx == TC_HI_IDX[a]) begin
          hit     = 1'b1;
          rd_byte = {6'h00, tc_reg[a][9:8]};
        end
        if (idx == TC_LO_IDX[a]) begin
          hit     = 1'b1;
          rd_byte = tc_reg[a][7:0];
        end
        if (idx == UOFF_HI_IDX[a]) begin
          hit     = 1'b1;
          rd_byte = uoff_reg[a][15:8];
        end
        if (idx == UOFF_LO_IDX[a]) begin
          hit     = 1'b1;
          rd_byte = uoff_reg[a][7:0];
        end
        if (idx == GOUT_HI_IDX[a]) begin
          hit     = 1'b1;
          rd_byte = gout_reg[a][15:8];
        end
        if (idx == GOUT_LO_IDX[a]) begin
          hit     = 1'b1;
          rd_byte = gout_reg[a][7:0];
        end
      end
      if (idx == DIV_IDX) begin
        hit     = 1'b1;
        rd_byte = div_reg;
      end
      if (idx == CFG_IDX) begin
        hit     = 1'b1;
        rd_byte = cfg_reg;
      end
      if (idx == GCFG_IDX) begin
        hit     = 1'b1;
        rd_byte = gcfg_reg;
      end
      if (idx == PWR_IDX) begin
        hit     = 1'b1;
        rd_byte = {1'b0, sleep_reg, 6'h00};
      end
    end
  end

  assign prdata = {24'h000000, rd_byte};

  //////////////////////////////////////////////////////////////////////////
  // configuration registers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int a = 0; a < AXES; a++) begin
        uoff_reg[a] <= UOFF_RESET;
      end
      div_reg  <= REG_RESET;
      cfg_reg  <= REG_RESET;
      gcfg_reg <= REG_RESET;
    end else if (soft_rst) begin
      for (int a = 0; a < AXES; a++) begin
        uoff_reg[a] <= UOFF_RESET;
      end
      div_reg  <= REG_RESET;
      cfg_reg  <= REG_RESET;
      gcfg_reg <= REG_RESET;
    end else if (wr_en) begin
      for (int a = 0; a < AXES; a++) begin
        if (idx == UOFF_HI_IDX[a]) begin
          uoff_reg[a][15:8] <= pwdata[7:0];
        end
        if (idx == UOFF_LO_IDX[a]) begin
          uoff_reg[a][7:0] <= pwdata[7:0];
        end
      end
      if (idx == DIV_IDX) begin
        div_reg <= pwdata[7:0];
      end
      if (idx == CFG_IDX) begin
        cfg_reg <= pwdata[7:0] & CFG_MASK;
      end
      if (idx == GCFG_IDX) begin
        gcfg_reg <= pwdata[7:0] & GCFG_MASK;
      end
    end
  end

  // awake after reset; sleep only by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_reg <= 1'b0;
    end else if (soft_rst) begin
      sleep_reg <= 1'b0;
    end else if (wr_en && idx == PWR_IDX) begin
      sleep_reg <= pwdata[PWR_SLEEP_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // temperature coefficients: trim reload, then software owned

  // trim pins are sampled after release, never inside the async reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_pending_reg <= 1'b1;
    end else begin
      load_pending_reg <= soft_rst;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int a = 0; a < AXES; a++) begin
        tc_reg[a] <= 10'h000;
      end
    end else if (load_pending_reg) begin
      for (int a = 0; a < AXES; a++) begin
        tc_reg[a] <= trim[a];
      end
    end else if (wr_en) begin
      for (int a = 0; a < AXES; a++) begin
        if (idx == TC_HI_IDX[a]) begin
          tc_reg[a][9:8] <= pwdata[TC_HI_BITS-1:0];
        end
        if (idx == TC_LO_IDX[a]) begin
          tc_reg[a][7:0] <= pwdata[7:0];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // conditioning datapath

  // no enable gate on the temperature term by design
  for (genvar g = 0; g < AXES; g++) begin : g_axis
    axis_condition u_cond (
      .raw               (raw[g]),
      .user_offset       (uoff_reg[g]),
      .temp_compensation (tc_reg[g]),
      .temp_delta        (temp_delta),
      .result            (cond[g])
    );
  end

  //////////////////////////////////////////////////////////////////////////
  // sample rate selection and pacing

  assign filter_path_select = gcfg_reg[FPS_LSB+1:FPS_LSB];
  assign lowpass_config     = cfg_reg[LPC_LSB+2:LPC_LSB];
  assign div_effective = (filter_path_select == 2'b00) &&
                         (lowpass_config != 3'h0) && (lowpass_config != 3'h7);

  always_comb begin
    if (filter_path_select != 2'b00) begin
      base_sel = RATE_SEL_32K;
    end else if (!div_effective) begin
      base_sel = RATE_SEL_8K;
    end else begin
      base_sel = RATE_SEL_1K;
    end
  end

  base_tick_gen #(
    .CYC_1K_P  (CYC_1K_P),
    .CYC_8K_P  (CYC_8K_P),
    .CYC_32K_P (CYC_32K)
  ) u_tick (
    .pclk     (pclk),
    .presetn  (presetn),
    .restart  (soft_rst),
    .rate_sel (base_sel),
    .tick     (base_tick)
  );

  // counter reloads on each strobe so a new divider applies next period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_reg <= 8'h00;
    end else if (soft_rst || !div_effective) begin
      div_cnt_reg <= 8'h00;
    end else if (base_tick) begin
      if (div_cnt_reg == 8'h00) begin
        div_cnt_reg <= div_reg;
      end else begin
        div_cnt_reg <= div_cnt_reg - 8'h01;
      end
    end
  end

  assign sample_strobe = !sleep_reg && base_tick &&
                         (!div_effective || div_cnt_reg == 8'h00);

  //////////////////////////////////////////////////////////////////////////
  // output registers and fifo push

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int a = 0; a < AXES; a++) begin
        gout_reg[a] <= 16'h0000;
      end
    end else if (soft_rst) begin
      for (int a = 0; a < AXES; a++) begin
        gout_reg[a] <= 16'h0000;
      end
    end else if (sample_strobe) begin
      for (int a = 0; a < AXES; a++) begin
        gout_reg[a] <= cond[a];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_push_reg <= 1'b0;
    end else begin
      fifo_push_reg <= sample_strobe && !soft_rst;
    end
  end

  assign gyro_x_out = gout_reg[0];
  assign gyro_y_out = gout_reg[1];
  assign gyro_z_out = gout_reg[2];
  assign fifo_push  = fifo_push_reg;
  assign sleep_out  = sleep_reg;

  //////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_wake;
    soft_rst |=> !sleep_reg && !sleep_out;
  endproperty
  a_wake: assert property (p_wake) else $error("sleep set after reset");

  property p_trim_load;
    load_pending_reg |=> tc_reg[0] == $past(trim_x) && tc_reg[2] == $past(trim_z);
  endproperty
  a_trim_load: assert property (p_trim_load) else $error("trim not loaded");

  property p_zero_coeff;
    tc_reg[1] == 10'h000 |-> cond[1] == 16'(raw_y - uoff_reg[1]);
  endproperty
  a_zero_coeff: assert property (p_zero_coeff) else $error("zero coeff changed data");

  property p_tc_hold;
    wr_en && idx == TC_LO_IDX[0] && !load_pending_reg && !soft_rst
      |=> tc_reg[0][7:0] == $past(pwdata[7:0]) ##1 (load_pending_reg || $stable(tc_reg[0]));
  endproperty
  a_tc_hold: assert property (p_tc_hold) else $error("written coeff lost");

  property p_subtract;
    sample_strobe && !soft_rst |=> gyro_x_out == $past(cond[0]) && fifo_push;
  endproperty
  a_subtract: assert property (p_subtract) else $error("output not conditioned");

  property p_fixed_rate;
    !div_effective && !sleep_reg |-> sample_strobe == base_tick;
  endproperty
  a_fixed_rate: assert property (p_fixed_rate) else $error("divider applied");

  property p_32k;
    filter_path_select != 2'b00 |-> base_sel == RATE_SEL_32K && !div_effective;
  endproperty
  a_32k: assert property (p_32k) else $error("path select not 32k");

  property p_reload;
    sample_strobe && div_effective && !soft_rst |=> div_cnt_reg == $past(div_reg);
  endproperty
  a_reload: assert property (p_reload) else $error("divider not reloaded");

  property p_soft_defaults;
    soft_rst |=> div_reg == REG_RESET && uoff_reg[0] == UOFF_RESET && load_pending_reg;
  endproperty
  a_soft_defaults: assert property (p_soft_defaults) else $error("reset values wrong");

  property p_div_write;
    wr_en && idx == DIV_IDX && !soft_rst |=> div_reg == $past(pwdata[7:0]);
  endproperty
  a_div_write: assert property (p_div_write) else $error("divider write lost");

  c_divided:  cover property (sample_strobe && div_effective && div_reg != 8'h00);
  c_32k:      cover property (sample_strobe && base_sel == RATE_SEL_32K);
  c_tc_write: cover property (wr_en && idx == TC_HI_IDX[2]);
  c_soft_rst: cover property (soft_rst);
endmodule

// File: gyro_offset_and_sample_rate_tb_top.sv
// self-checking bench for the gyro offset and sample-rate block.
// assumes package and design files compiled first; bench is the APB master.
`timescale 1ns/1ns
module gyro_offset_and_sample_rate_tb_top;
  import gyro_cond_pkg::*;
  localparam int C1 = 20;
  localparam int C8 = 8;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        fifo_push, sleep_out;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  logic [15:0] raw [3];
  logic [15:0] gout [3];
  logic [9:0]  trim [3];
  logic [15:0] temp_delta;
  int          errors, n_compared;
  int          m_tc [3];
  int          m_uoff [3];
  int          m_div;
  int          tp [8] = '{0, 0, 0, 0, 0, 1, 2, 3};
  int          lc [8] = '{1, 6, 3, 0, 7, 1, 5, 1};
  int          dv [8] = '{0, 3, 255, 5, 5, 9, 0, 0};

  gyro_offset_and_sample_rate #(.CYC_1K_P(C1), .CYC_8K_P(C8)) i_gyro_offset_and_sample_rate (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .raw_x(raw[0]), .raw_y(raw[1]), .raw_z(raw[2]),
    .temp_delta(temp_delta), .trim_x(trim[0]), .trim_y(trim[1]), .trim_z(trim[2]),
    .gyro_x_out(gout[0]), .gyro_y_out(gout[1]), .gyro_z_out(gout[2]),
    .fifo_push(fifo_push), .sleep_out(sleep_out));

  initial pclk = 1'b0;
  always #10 pclk = ~pclk;

  //////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    if (errors == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t value got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_gap(input int got, input int exp);
    n_compared++;
    if (got != exp) begin
      errors++;
      $display("ERROR %0t sample gap got %0d expected %0d", $time, got, exp);
    end
  endtask

  // request held until pready seen high at a rising edge; data taken there
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d,
                     output logic [7:0] rd, output logic err);
    int   n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // pready, read data and error all taken at the same rising edge
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata[7:0];
    err = pslverr;
    if (pready !== 1'b1) begin
      errors++;
      $display("ERROR %0t bus answer timeout", $time);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] r;
    logic       e;
    apb(1'b1, idx, d, r, e);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] r;
    logic       e;
    apb(1'b0, idx, 8'h00, r, e);
    chk_val({8'h00, r}, {8'h00, exp});
  endtask

  // cycles from one push to the next; a missing push counts as a mismatch
  task automatic wait_push(input int lim, output int n);
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (fifo_push !== 1'b1 && n < lim);
    if (n >= lim) begin
      errors++;
      $display("ERROR %0t no sample push", $time);
    end
  endtask

  task automatic check_regs;
    logic [9:0] t;
    for (int a = 0; a < AXES; a++) begin
      t = m_tc[a][9:0];
      rd_chk(TC_HI_IDX[a], {6'h00, t[9:8]});
      rd_chk(TC_LO_IDX[a], t[7:0]);
      rd_chk(UOFF_HI_IDX[a], m_uoff[a][15:8]);
      rd_chk(UOFF_LO_IDX[a], m_uoff[a][7:0]);
    end
    rd_chk(DIV_IDX, m_div[7:0]);
  endtask

  function automatic logic [15:0] cond(input int a);
    int p;
    p = (m_tc[a] * $signed(temp_delta)) >>> COMP_SHIFT;
    return raw[a] - m_uoff[a][15:0] - p[15:0];
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // run needs roughly 15k cycles; limit at 50k keeps the bench bounded
  initial begin
    #1_000_000;
    errors++;
    $display("ERROR %0t watchdog expired", $time);
    end_sim();
  end

  initial begin
    int         g;
    logic [7:0] r;
    logic       e;
    void'($urandom(8112));
    errors = 0;
    n_compared = 0;
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'b000;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    pstrb = 4'hF;
    temp_delta = 16'h0000;
    for (int a = 0; a < AXES; a++) begin
      raw[a] = 16'h0000;
      trim[a] = 10'($urandom);
      m_tc[a] = $signed(trim[a]);
      m_uoff[a] = 0;
    end
    m_div = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk_val({15'h0000, sleep_out}, 16'h0000);
    check_regs();
    apb(1'b0, 8'h30, 8'h00, r, e);
    chk_val({7'h00, e, r}, 16'h0100);
    // pass 0 keeps trimmed coefficients, pass 1 zeroes them
    for (int pass = 0; pass < 2; pass++) begin
      @(posedge pclk);
      temp_delta <= 16'($urandom);
      for (int a = 0; a < AXES; a++) begin
        raw[a] <= 16'($urandom);
        m_uoff[a] = $urandom_range(0, 65535);
        wr(UOFF_HI_IDX[a], m_uoff[a][15:8]);
        wr(UOFF_LO_IDX[a], m_uoff[a][7:0]);
        if (pass == 1) begin
          wr(TC_HI_IDX[a], 8'h00);
          wr(TC_LO_IDX[a], 8'h00);
          m_tc[a] = 0;
        end
      end
      m_div = $urandom_range(0, 3);
      wr(DIV_IDX, m_div[7:0]);
      check_regs();
      wait_push(400, g);
      wait_push(400, g);
      for (int a = 0; a < AXES; a++) begin
        chk_val(gout[a], cond(a));
        rd_chk(GOUT_HI_IDX[a], 8'(cond(a) >> 8));
        rd_chk(GOUT_LO_IDX[a], 8'(cond(a)));
      end
    end
    // a write without its low byte strobe leaves the register alone
    pstrb <= 4'hE;
    wr(DIV_IDX, ~m_div[7:0]);
    pstrb <= 4'hF;
    rd_chk(DIV_IDX, m_div[7:0]);
    // every path/config class, divider at 0 and at its top value
    for (int i = 0; i < 8; i++) begin
      m_div = dv[i];
      wr(DIV_IDX, m_div[7:0]);
      wr(CFG_IDX, lc[i][7:0]);
      wr(GCFG_IDX, tp[i][7:0]);
      rd_chk(GCFG_IDX, tp[i][7:0]);
      wait_push(12000, g);
      wait_push(12000, g);
      if (tp[i] != 0) begin
        chk_gap(g, CYC_32K);
      end else if (lc[i] == 0 || lc[i] == 7) begin
        chk_gap(g, C8);
      end else begin
        chk_gap(g, C1 * (dv[i] + 1));
      end
    end
    // device reset reloads fresh trim and clears the user settings
    @(posedge pclk);
    for (int a = 0; a < AXES; a++) begin
      trim[a] <= 10'($urandom);
    end
    @(posedge pclk);
    for (int a = 0; a < AXES; a++) begin
      m_tc[a] = $signed(trim[a]);
      m_uoff[a] = 0;
    end
    m_div = 0;
    // sleep first, so the device reset has something to clear
    wr(PWR_IDX, 8'h40);
    @(negedge pclk);
    chk_val({15'h0000, sleep_out}, 16'h0001);
    wr(PWR_IDX, 8'h80);
    @(negedge pclk);
    chk_val({15'h0000, sleep_out}, 16'h0000);
    check_regs();
    end_sim();
  end
endmodule
